/* File: hdl/prcg_pkg.sv */
// Constants for the peripheral reset and clock gating block
package prcg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  RST_REG_OFFSET  = 8'h10;
  localparam logic [7:0]  CLK_REG_OFFSET  = 8'h14;
  localparam logic [31:0] RST_REG_RESET   = 32'h00000000;
  localparam logic [31:0] CLK_REG_RESET   = 32'h00000014;
  // Implemented bits; all others are reserved and read as reset value
  localparam logic [31:0] RST_REG_MASK    = 32'h00000A7F;
  localparam logic [31:0] CLK_REG_MASK    = 32'h00001A55;

  // ----------------------------------------------------------------
  // Reset register fields
  // ----------------------------------------------------------------
  localparam int TIMER_TWO_BIT   = 0;
  localparam int TIMER_THREE_BIT = 1;
  localparam int TIMER_FOUR_BIT  = 2;
  localparam int TIMER_FIVE_BIT  = 3;
  localparam int TIMER_SIX_BIT   = 4;
  localparam int TIMER_SEVEN_BIT = 5;
  localparam int COMPARATOR_BIT  = 6;
  localparam int TIMER_NINE_BIT  = 9;
  localparam int WINDOW_DOG_BIT  = 11;

  // ----------------------------------------------------------------
  // Clock enable register fields
  // ----------------------------------------------------------------
  localparam int TRANSFER_ENGINE_BIT = 0;
  localparam int RAM_SLEEP_BIT       = 2;
  localparam int FLASH_IFACE_BIT     = 4;
  localparam int CHECKSUM_BIT        = 6;
  localparam int RANDOM_GEN_BIT      = 9;
  localparam int AUDIO_BLOCK_BIT     = 11;
  localparam int CONVERTER_BIT       = 12;

  // Number of gated clocks
  localparam int NUM_GATES = 7;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: hdl/prcg_clock_gate.sv */
// Glitch-free clock gate with enable retimed on the falling edge
`timescale 1ns/100ps
module prcg_clock_gate #(
  parameter logic RST_ON = 1'b0
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic en,
  output wire logic gclk
);

  logic en_lo_ff;

  // Enable only changes while clock is low, so no runt pulses
  always_ff @(negedge clock or posedge rst) begin
    if (rst) begin
      en_lo_ff <= RST_ON;
    end else if (ce) begin
      en_lo_ff <= en;
    end
  end

  assign gclk = clock & en_lo_ff;

endmodule

/* File: hdl/prcg_top.sv */
// Peripheral reset and clock gating registers with AXI4-Lite slave
// ----------------------------------------------------------------
// Behaviour
// - Software alone sets and clears reset holds
// - Timer holds at bits 0-5 and 9
// - Bit 11 holds window watchdog in reset
// - Bit 6 holds comparator in reset
// - Clock register resets to 0x14
// - Bit 12 gates converter clock
// - Bit 11 gates audio block clock
// - Bit 9 gates random generator clock
// - Bit 6 gates checksum unit clock
// - Bit 4 gates flash interface clock
// - Bit 2 keeps RAM clock during sleep
// - Bit 0 gates transfer engine clock
// - Reset register at 0x10, resets to zero
// ----------------------------------------------------------------
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
module prcg_top (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        sleep_mode,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Peripheral reset holds
  output wire logic        timer_two_hold,
  output wire logic        timer_three_hold,
  output wire logic        timer_four_hold,
  output wire logic        timer_five_hold,
  output wire logic        timer_six_hold,
  output wire logic        timer_seven_hold,
  output wire logic        timer_nine_hold,
  output wire logic        comparator_hold,
  output wire logic        window_dog_hold,
  // Gated peripheral clocks
  output wire logic        converter_clk,
  output wire logic        audio_block_clk,
  output wire logic        random_gen_clk,
  output wire logic        checksum_clk,
  output wire logic        flash_iface_clk,
  output wire logic        ram_clk,
  output wire logic        transfer_engine_clk
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] rst_reg_ff;
  logic [31:0] clk_reg_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        arready_ff;
  logic        rvalid_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rdata_ff;
  logic [7:0]  waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire         aw_take   = s_axi_awvalid & awready_ff;
  wire         w_take    = s_axi_wvalid & wready_ff;
  wire         b_take    = bvalid_ff & s_axi_bready;
  wire         ar_take   = s_axi_arvalid & arready_ff;
  wire         r_take    = rvalid_ff & s_axi_rready;
  // Both halves held once both readies have dropped
  wire         wr_go     = ~awready_ff & ~wready_ff & ~bvalid_ff;
  wire         wr_rst    = waddr_ff == prcg_pkg::RST_REG_OFFSET;
  wire         wr_clk    = waddr_ff == prcg_pkg::CLK_REG_OFFSET;
  wire         rd_rst    = s_axi_araddr == prcg_pkg::RST_REG_OFFSET;
  wire         rd_clk    = s_axi_araddr == prcg_pkg::CLK_REG_OFFSET;
  wire         rd_hit    = rd_rst | rd_clk;
  wire [31:0]  rd_mux    = rd_rst ? rst_reg_ff :
                           rd_clk ? clk_reg_ff : 32'h00000000;
  logic [31:0] byte_mask;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_strb
      assign byte_mask[gb*8 +: 8] = {8{wstrb_ff[gb]}};
    end
  endgenerate

  // Reserved bits never take written data
  wire [31:0] rst_wmask = byte_mask & prcg_pkg::RST_REG_MASK;
  wire [31:0] clk_wmask = byte_mask & prcg_pkg::CLK_REG_MASK;
  wire [31:0] nxt_rst_reg =
    (rst_reg_ff & ~rst_wmask) | (wdata_ff & rst_wmask);
  wire [31:0] nxt_clk_reg =
    (clk_reg_ff & ~clk_wmask) | (wdata_ff & clk_wmask);

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awready_ff <= 1'b1;
      waddr_ff   <= 8'h00;
    end else if (ce) begin
      if (aw_take) begin
        awready_ff <= 1'b0;
        waddr_ff   <= s_axi_awaddr;
      end else if (b_take) begin
        awready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wready_ff <= 1'b1;
      wdata_ff  <= 32'h00000000;
      wstrb_ff  <= 4'h0;
    end else if (ce) begin
      if (w_take) begin
        wready_ff <= 1'b0;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end else if (b_take) begin
        wready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= prcg_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (wr_rst | wr_clk) ? prcg_pkg::RESP_OKAY
                                       : prcg_pkg::RESP_SLVERR;
      end else if (b_take) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Reset holds change only by software writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rst_reg_ff <= prcg_pkg::RST_REG_RESET;
    end else if (ce && wr_go && wr_rst) begin
      rst_reg_ff <= nxt_rst_reg;
    end
  end

  // Flash and RAM sleep enables are on out of reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clk_reg_ff <= prcg_pkg::CLK_REG_RESET;
    end else if (ce && wr_go && wr_clk) begin
      clk_reg_ff <= nxt_clk_reg;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= prcg_pkg::RESP_OKAY;
      rdata_ff   <= 32'h00000000;
    end else if (ce) begin
      if (ar_take) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rdata_ff   <= rd_mux;
        rresp_ff   <= rd_hit ? prcg_pkg::RESP_OKAY
                             : prcg_pkg::RESP_SLVERR;
      end else if (r_take) begin
        arready_ff <= 1'b1;
        rvalid_ff  <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  // ----------------------------------------------------------------
  // Reset holds
  // ----------------------------------------------------------------
  // Timer holds
  assign timer_two_hold   = rst_reg_ff[prcg_pkg::TIMER_TWO_BIT];
  assign timer_three_hold = rst_reg_ff[prcg_pkg::TIMER_THREE_BIT];
  assign timer_four_hold  = rst_reg_ff[prcg_pkg::TIMER_FOUR_BIT];
  assign timer_five_hold  = rst_reg_ff[prcg_pkg::TIMER_FIVE_BIT];
  assign timer_six_hold   = rst_reg_ff[prcg_pkg::TIMER_SIX_BIT];
  assign timer_seven_hold = rst_reg_ff[prcg_pkg::TIMER_SEVEN_BIT];
  assign timer_nine_hold  = rst_reg_ff[prcg_pkg::TIMER_NINE_BIT];
  // Comparator interface hold
  assign comparator_hold  = rst_reg_ff[prcg_pkg::COMPARATOR_BIT];
  // Window watchdog hold
  assign window_dog_hold  = rst_reg_ff[prcg_pkg::WINDOW_DOG_BIT];

  // ----------------------------------------------------------------
  // Clock gates
  // ----------------------------------------------------------------
  logic [prcg_pkg::NUM_GATES-1:0] gate_en;
  logic [prcg_pkg::NUM_GATES-1:0] gate_clk;

  // Gate positions within the gate vector
  localparam int G_CONVERTER       = 6;
  localparam int G_AUDIO_BLOCK     = 5;
  localparam int G_RANDOM_GEN      = 4;
  localparam int G_CHECKSUM        = 3;
  localparam int G_FLASH_IFACE     = 2;
  localparam int G_RAM             = 1;
  localparam int G_TRANSFER_ENGINE = 0;

  // RAM clock runs outside sleep; in sleep only when enabled
  wire ram_run = ~sleep_mode | clk_reg_ff[prcg_pkg::RAM_SLEEP_BIT];

  assign gate_en = {
    clk_reg_ff[prcg_pkg::CONVERTER_BIT],
    clk_reg_ff[prcg_pkg::AUDIO_BLOCK_BIT],
    clk_reg_ff[prcg_pkg::RANDOM_GEN_BIT],
    clk_reg_ff[prcg_pkg::CHECKSUM_BIT],
    clk_reg_ff[prcg_pkg::FLASH_IFACE_BIT],
    ram_run,
    clk_reg_ff[prcg_pkg::TRANSFER_ENGINE_BIT]
  };

  // Gate flops start from the register's reset value; the RAM gate
  // starts on since the system is awake out of reset
  localparam logic [prcg_pkg::NUM_GATES-1:0] GATE_RST = {
    prcg_pkg::CLK_REG_RESET[prcg_pkg::CONVERTER_BIT],
    prcg_pkg::CLK_REG_RESET[prcg_pkg::AUDIO_BLOCK_BIT],
    prcg_pkg::CLK_REG_RESET[prcg_pkg::RANDOM_GEN_BIT],
    prcg_pkg::CLK_REG_RESET[prcg_pkg::CHECKSUM_BIT],
    prcg_pkg::CLK_REG_RESET[prcg_pkg::FLASH_IFACE_BIT],
    1'b1,
    prcg_pkg::CLK_REG_RESET[prcg_pkg::TRANSFER_ENGINE_BIT]
  };

  genvar gg;
  generate
    for (gg = 0; gg < prcg_pkg::NUM_GATES; gg++) begin : g_gate
      // Glitch-free gate per peripheral
      prcg_clock_gate #(
        .RST_ON (GATE_RST[gg])
      ) u_gate (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .en    (gate_en[gg]),
        .gclk  (gate_clk[gg])
      );
    end
  endgenerate

  assign converter_clk       = gate_clk[G_CONVERTER];
  assign audio_block_clk     = gate_clk[G_AUDIO_BLOCK];
  assign random_gen_clk      = gate_clk[G_RANDOM_GEN];
  assign checksum_clk        = gate_clk[G_CHECKSUM];
  assign flash_iface_clk     = gate_clk[G_FLASH_IFACE];
  assign ram_clk             = gate_clk[G_RAM];
  assign transfer_engine_clk = gate_clk[G_TRANSFER_ENGINE];

endmodule

/* File: tb/prcg_monitor.sv */
// Port checker for the reset and clock gating block
`timescale 1ns/100ps
module prcg_monitor (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        sleep_mode,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        timer_two_hold,
  input wire logic        comparator_hold,
  input wire logic        window_dog_hold,
  input wire logic        flash_iface_clk,
  input wire logic        ram_clk,
  input wire logic        transfer_engine_clk
);
  wire [2:0] holds = {window_dog_hold, comparator_hold, timer_two_hold};
  wire [2:0] gates = {flash_iface_clk, ram_clk, transfer_engine_clk};
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_hold_write: assert property (
    !$rose(s_axi_bvalid) |-> $stable(holds)) else $error("hold moved");
  chk_aw_blocked: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw open");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  chk_r_latency: assert property (ce && s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("r late");
  chk_b_latency: assert property (ce && s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("b late");
  chk_gate_low: assert property (gates == 3'h0)
    else $error("gated clock high in low phase");
  chk_ram_awake: assert property (
    @(negedge clock) disable iff (rst) $past(ce && !sleep_mode) |-> ram_clk)
    else $error("ram clock stopped while awake");
  chk_rsvd_zero: assert property (s_axi_rvalid |-> (s_axi_rdata &
    ~(prcg_pkg::RST_REG_MASK | prcg_pkg::CLK_REG_MASK)) == 32'h0)
    else $error("reserved bit set");
endmodule
bind prcg_top prcg_monitor u_prcg_monitor (.clock, .rst, .ce, .sleep_mode,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .timer_two_hold, .comparator_hold,
  .window_dog_hold, .flash_iface_clk, .ram_clk, .transfer_engine_clk);

/* File: tb/tb_prcg_top.sv */
// Self-checking bench for the reset and clock gating registers
`timescale 1ns/100ps
module tb_prcg_top;
  localparam logic [1:0] OK  = prcg_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = prcg_pkg::RESP_SLVERR;
  logic        clock, rst, ce, sleep_mode;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, timer_two_hold, timer_three_hold;
  logic        timer_four_hold, timer_five_hold, timer_six_hold;
  logic        timer_seven_hold, timer_nine_hold, comparator_hold;
  logic        window_dog_hold, converter_clk, audio_block_clk;
  logic        random_gen_clk, checksum_clk, flash_iface_clk, ram_clk;
  logic        transfer_engine_clk;
  int          bad_count, tests_run;
  wire [8:0] holds = {window_dog_hold, timer_nine_hold, comparator_hold,
    timer_seven_hold, timer_six_hold, timer_five_hold, timer_four_hold,
    timer_three_hold, timer_two_hold};
  wire [6:0] gates = {converter_clk, audio_block_clk, random_gen_clk,
    checksum_clk, flash_iface_clk, ram_clk, transfer_engine_clk};
  prcg_top u_prcg_top (.clock, .rst, .ce, .sleep_mode, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .timer_two_hold, .timer_three_hold, .timer_four_hold,
    .timer_five_hold, .timer_six_hold, .timer_seven_hold, .timer_nine_hold,
    .comparator_hold, .window_dog_hold, .converter_clk, .audio_block_clk,
    .random_gen_clk, .checksum_clk, .flash_iface_clk, .ram_clk,
    .transfer_engine_clk);
  always #2 clock = ~clock;
  // ----
  // Checking and bus tasks
  // ----
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic bump(inout int n);
    n++;
    if (n > 40) begin
      bad_count++;
      $display("mismatch at %0t: bus timeout", $time);
      give_verdict;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int         n;
    logic       aw_hit, w_hit, b_hit;
    logic [1:0] resp;
    n = 0;
    b_hit = 1'b0;
    resp = 2'h0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      // Handshakes judged on values standing before the rising edge
      @(negedge clock);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      b_hit = (s_axi_bvalid === 1'b1);
      resp = s_axi_bresp;
      @(posedge clock);
      bump(n);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
    end while (!b_hit);
    s_axi_bready <= 1'b0;
    cmp({30'h0, resp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int          n;
    logic        ar_hit, r_hit;
    logic [31:0] data;
    logic [1:0]  resp;
    n = 0;
    r_hit = 1'b0;
    data = 32'h00000000;
    resp = 2'h0;
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge clock);
      ar_hit = s_axi_arvalid && s_axi_arready;
      r_hit = (s_axi_rvalid === 1'b1);
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clock);
      bump(n);
      if (ar_hit) s_axi_arvalid <= 1'b0;
    end while (!r_hit);
    s_axi_rready <= 1'b0;
    cmp(data, ed);
    cmp({30'h0, resp}, {30'h0, er});
  endtask
  task automatic hcheck(input logic [31:0] r);
    cmp({23'h0, holds}, {23'h0, r[11], r[9], r[6], r[5:0]});
  endtask
  task automatic gcheck(input logic [31:0] r);
    repeat (3) @(posedge clock);
    #1;
    cmp({25'h0, gates}, {25'h0, r[12], r[11], r[9], r[6], r[4],
        !sleep_mode | r[2], r[0]});
  endtask
  // ----
  // Scenarios
  // ----
  task automatic reset_values;
    rd(8'h10, 32'h00000000, OK);
    rd(8'h14, 32'h00000014, OK);
    hcheck(32'h00000000);
    gcheck(32'h00000014);
  endtask
  task automatic hold_bits;
    int b[9] = '{0, 1, 2, 3, 4, 5, 6, 9, 11};
    foreach (b[i]) begin
      wr(8'h10, 32'h1 << b[i], OK);
      hcheck(32'h1 << b[i]);
      rd(8'h10, 32'h1 << b[i], OK);
    end
    wr(8'h10, 32'h00000A7F, OK);
    rd(8'h10, 32'h00000A7F, OK);
    wr(8'h10, 32'h00000000, OK);
    hcheck(32'h00000000);
  endtask
  task automatic gate_bits;
    int b[7] = '{0, 2, 4, 6, 9, 11, 12};
    foreach (b[i]) begin
      wr(8'h14, 32'h1 << b[i], OK);
      gcheck(32'h1 << b[i]);
    end
    wr(8'h14, 32'h00001A55, OK);
    rd(8'h14, 32'h00001A55, OK);
  endtask
  task automatic sleep_ram;
    wr(8'h14, 32'h00000000, OK);
    sleep_mode <= 1'b1;
    gcheck(32'h00000000);
    wr(8'h14, 32'h00000004, OK);
    gcheck(32'h00000004);
    sleep_mode <= 1'b0;
    wr(8'h14, 32'h00000014, OK);
  endtask
  task automatic ce_freeze;
    wr(8'h14, 32'h00000010, OK);
    @(posedge clock);
    ce <= 1'b0;
    sleep_mode <= 1'b1;
    // Frozen gate keeps the RAM clock running into sleep
    gcheck(32'h00000014);
    ce <= 1'b1;
    gcheck(32'h00000010);
    sleep_mode <= 1'b0;
    wr(8'h14, 32'h00000014, OK);
  endtask
  task automatic unmapped;
    wr(8'h10, 32'h00000800, OK);
    wr(8'h20, 32'hFFFFFFFF, ERR);
    rd(8'h20, 32'h00000000, ERR);
    rd(8'h10, 32'h00000800, OK);
    rd(8'h14, 32'h00000014, OK);
  endtask
  initial begin
    {clock, rst, ce, sleep_mode} = 4'h6;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    bad_count = 0;
    tests_run = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    reset_values;
    hold_bits;
    gate_bits;
    sleep_ram;
    ce_freeze;
    unmapped;
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    reset_values;
    give_verdict;
  end
endmodule
